// ### sld_ctrl.sv
// controller end: APB slave that shifts a pattern out and strobes it
// assumes the device resynchronises the pins on its own clock
module sld_ctrl #(
    parameter int CHANNELS = sld_pkg::SLD_CHANNELS
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // link pins
    sld_link_if.ctrl link
);
    import sld_pkg::*;
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        sld_state_t fsm;
        logic [SLD_CNT_W-1:0] tmr;     // phase timer
        logic [3:0] bitCnt;            // bits left
        logic [CHANNELS-1:0] data;     // pattern register
        logic [CHANNELS-1:0] shf;      // pattern being sent
        logic oeOff;                   // hold enable high
        logic done;                    // sticky done event
        logic irqEn;                   // done enable
        logic sclk, sdat, strb, oen;   // pin flops
        logic [31:0] rd;               // read data
        logic rdy;                     // access answer
        logic err;
        logic irqQ;
    } sld_ctl_t;
    sld_ctl_t st_q, st_d;
    logic acc;      // access phase, answered one cycle later
    logic evDone;

    always_comb begin
        st_d = st_q;
        acc = psel && penable && !st_q.rdy;
        evDone = 1'b0;
        st_d.rdy = acc;
        st_d.err = 1'b0;
        st_d.rd = '0;
        if (st_q.tmr != '0) begin
            st_d.tmr = st_q.tmr - SLD_CNT_W'(1);
        end
        // ************************************************************
        // link sequencer
        // ************************************************************
        unique case (st_q.fsm)
            SLD_IDLE: begin
                st_d.sclk = 1'b0;
                st_d.strb = 1'b0;
            end
            SLD_SETUP: if (st_q.tmr == '0) begin
                st_d.sclk = 1'b1;
                st_d.tmr = SLD_CNT_W'(SLD_SCLK_PULSE_CYC);
                st_d.fsm = SLD_HIGH;
            end
            SLD_HIGH: if (st_q.tmr == '0) begin
                st_d.sclk = 1'b0;
                st_d.shf = {st_q.shf[CHANNELS-2:0], 1'b0};
                st_d.bitCnt = st_q.bitCnt - 4'(1);
                if (st_q.bitCnt == 4'(1)) begin
                    st_d.tmr = SLD_CNT_W'(SLD_CLK_TO_STROBE_CYC);
                    st_d.fsm = SLD_GAP;
                end else begin
                    st_d.sdat = st_q.shf[CHANNELS-2];
                    st_d.tmr = SLD_CNT_W'(SLD_SCLK_PULSE_CYC);
                    st_d.fsm = SLD_SETUP;
                end
            end
            SLD_GAP: if (st_q.tmr == '0) begin
                st_d.strb = 1'b1;
                st_d.tmr = SLD_CNT_W'(SLD_STROBE_PULSE_CYC);
                st_d.fsm = SLD_STROBE;
            end
            SLD_STROBE: if (st_q.tmr == '0) begin
                st_d.strb = 1'b0;
                evDone = 1'b1;
                st_d.fsm = SLD_IDLE;
            end
            SLD_RSTP: if (st_q.tmr == '0) begin
                evDone = 1'b1;
                st_d.fsm = SLD_IDLE;
            end
        endcase
        // enable pin: pulse high to reset faults, else software level
        st_d.oen = st_q.oeOff || (st_d.fsm == SLD_RSTP);
        // ************************************************************
        // register access, taken in the access phase
        // ************************************************************
        if (acc && pwrite) begin
            unique case (paddr)
                SLD_REG_CTRL: begin
                    st_d.oeOff = pwdata[SLD_CTRL_OEOFF];
                    if (st_q.fsm == SLD_IDLE && pwdata[SLD_CTRL_GO]) begin
                        // zero pattern clears the outputs
                        st_d.shf = st_q.data;
                        st_d.sdat = st_q.data[CHANNELS-1];
                        st_d.bitCnt = 4'(CHANNELS);
                        st_d.tmr = SLD_CNT_W'(SLD_SCLK_PULSE_CYC);
                        st_d.fsm = SLD_SETUP;
                    end else if (st_q.fsm == SLD_IDLE && pwdata[SLD_CTRL_RST]) begin
                        st_d.tmr = SLD_CNT_W'(SLD_STROBE_PULSE_CYC);
                        st_d.fsm = SLD_RSTP;
                    end
                end
                SLD_REG_DATA: st_d.data = pwdata[CHANNELS-1:0];
                SLD_REG_IRQ_CLR: if (pwdata[0]) st_d.done = 1'b0;
                SLD_REG_IRQ_EN: st_d.irqEn = pwdata[0];
                SLD_REG_STAT, SLD_REG_IRQ_STAT: st_d.err = 1'b1;      // read only
                default: st_d.err = 1'b1;
            endcase
        end else if (acc) begin
            unique case (paddr)
                SLD_REG_CTRL: st_d.rd = {29'h0, 1'b0, st_q.oeOff, 1'b0};
                SLD_REG_DATA: st_d.rd = 32'(st_q.data);
                SLD_REG_STAT: st_d.rd = {31'h0, st_q.fsm != SLD_IDLE};
                SLD_REG_IRQ_STAT: st_d.rd = {31'h0, st_q.done};
                SLD_REG_IRQ_EN: st_d.rd = {31'h0, st_q.irqEn};
                SLD_REG_IRQ_CLR: st_d.rd = '0;
                default: st_d.err = 1'b1;
            endcase
        end
        // set wins over a clear in the same cycle
        if (evDone) begin
            st_d.done = 1'b1;
        end
        st_d.irqQ = st_d.done && st_d.irqEn;
    end

    // register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs from flip-flops
    assign prdata = st_q.rd;
    assign pready = st_q.rdy;
    assign pslverr = st_q.err;
    assign irq = st_q.irqQ;
    assign link.serData = st_q.sdat;
    assign link.shiftClk = st_q.sclk;
    assign link.strobe = st_q.strb;
    assign link.outEnN = st_q.oen;
endmodule

// ### sld_device.sv
// device end: shift register, latches, gating and protection logic
// assumes link pins are asynchronous and resynchronised here
module sld_device #(
    parameter int CHANNELS = sld_pkg::SLD_CHANNELS
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link pins
    sld_link_if.dev link,
    // protection sensors, asynchronous
    input wire logic [CHANNELS-1:0] overCur,
    input wire logic overTemp,
    input wire logic lowSupplyLockout,
    // driver outputs, high means sink on; fault flags, high means fault latched
    output logic [CHANNELS-1:0] sinkOn,
    output logic [CHANNELS-1:0] faultFlag
);
    import sld_pkg::*;
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [1:0] sclkS;              // shift clock synchroniser
        logic sclkPrev;                 // last synchronised level
        logic [1:0] dataS;              // serial data synchroniser
        logic [1:0] strobeS;            // strobe synchroniser
        logic [1:0] oenS;               // enable synchroniser
        logic oenPrev;                  // last enable level
        logic [1:0] tempS;              // thermal synchroniser
        logic [1:0] lvS;                // lockout synchroniser
        logic [CHANNELS-1:0] shiftReg;  // stage 0 is first
        logic [CHANNELS-1:0] latch;     // output latches
        logic [CHANNELS-1:0] sink;      // registered drive
        logic casc;                     // registered cascade
    } sld_dev_t;
    sld_dev_t st_q, st_d;
    logic [CHANNELS-1:0] ocS1_q, ocS2_q;  // over-current synchroniser
    logic [CHANNELS-1:0] fault;           // latched faults
    logic faultClr;                       // rising enable clears faults

    // ****************************************************************
    // over-current filters, one per channel
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ocS1_q <= '0;
            ocS2_q <= '0;
        end else begin
            ocS1_q <= overCur;
            ocS2_q <= ocS1_q;
        end
    end
    assign faultClr = st_q.oenS[1] && !st_q.oenPrev;  // pulse start clears
    generate
        for (genvar i = 0; i < CHANNELS; i++) begin : g_oc
            sld_oc_filter u_oc (
                .clk(clk),
                .sys_rst(sys_rst),
                .overCur(ocS2_q[i]),
                .faultClr(faultClr),
                .fault(fault[i])
            );
        end
    endgenerate

    // ****************************************************************
    // data path
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        // two flops before any use; edge found on the second only
        st_d.sclkS = {st_q.sclkS[0], link.shiftClk};
        st_d.dataS = {st_q.dataS[0], link.serData};
        st_d.strobeS = {st_q.strobeS[0], link.strobe};
        st_d.oenS = {st_q.oenS[0], link.outEnN};
        st_d.tempS = {st_q.tempS[0], overTemp};
        st_d.lvS = {st_q.lvS[0], lowSupplyLockout};
        st_d.sclkPrev = st_q.sclkS[1];
        st_d.oenPrev = st_q.oenS[1];
        // data sampled with the clock through equal delay, so setup holds
        if (st_q.sclkS[1] && !st_q.sclkPrev) begin
            st_d.shiftReg = {st_q.shiftReg[CHANNELS-2:0], st_q.dataS[1]};
        end
        if (st_q.strobeS[1]) begin
            st_d.latch = st_q.shiftReg;
        end
        st_d.casc = st_d.shiftReg[CHANNELS-1];
        // global shutdowns are level gated, never latched
        if (st_q.oenS[1] || st_q.tempS[1] || st_q.lvS[1]) begin
            st_d.sink = '0;
        end else begin
            st_d.sink = st_q.latch & ~fault;
        end
    end

    // register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // every output straight from a flip-flop
    assign link.cascadeOut = st_q.casc;
    assign sinkOn = st_q.sink;
    assign faultFlag = fault;
endmodule

// ### sld_link_if.sv
// interface carrying the serial driver pins between controller and device
// assumes both ends sample it on the same system clock
interface sld_link_if;
    logic serData;      // serial data to device
    logic shiftClk;     // shift clock from controller
    logic strobe;       // latch load strobe
    logic outEnN;       // output enable, low active; high pulse resets faults
    logic cascadeOut;   // last shift stage from device
    modport ctrl (output serData, output shiftClk, output strobe, output outEnN,
        input cascadeOut);
    modport dev (input serData, input shiftClk, input strobe, input outEnN,
        output cascadeOut);
endinterface

// ### sld_link_sva.sv
// checker for the link pins between controller end and device end
// assumes all pins are sampled on the shared system clock
module sld_link_sva (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link pins
    input wire logic serData,
    input wire logic shiftClk,
    input wire logic strobe,
    input wire logic outEnN,
    input wire logic cascadeOut
);
    // ****************************************************************
    // helper counters, saturating so long idle spans never wrap
    // ****************************************************************
    logic [7:0] hiCnt_q;    // cycles shift clock has been high
    logic [7:0] loCnt_q;    // cycles shift clock has been low
    logic [7:0] stbCnt_q;   // cycles strobe has been high
    logic [7:0] riseCnt_q;  // cycles since the last shift clock rise
    logic [7:0] shadow_q;   // reference copy of the shift chain
    logic clkPrev_q;        // shift clock one cycle ago

    function automatic logic [7:0] sat(input logic [7:0] v);
        return (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    // one process keeps every helper in step
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hiCnt_q <= 8'h00;
            loCnt_q <= 8'h00;
            stbCnt_q <= 8'h00;
            riseCnt_q <= 8'hFF;
            shadow_q <= 8'h00;
            clkPrev_q <= 1'b0;
        end else begin
            hiCnt_q <= shiftClk ? sat(hiCnt_q) : 8'h00;
            loCnt_q <= shiftClk ? 8'h00 : sat(loCnt_q);
            stbCnt_q <= strobe ? sat(stbCnt_q) : 8'h00;
            clkPrev_q <= shiftClk;
            // rising edge: capture data, chain moves toward cascade
            if (shiftClk && !clkPrev_q) begin
                shadow_q <= {shadow_q[6:0], serData};
                riseCnt_q <= 8'h00;
            end else begin
                riseCnt_q <= sat(riseCnt_q);
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ****************************************************************
    // assertions
    // ****************************************************************
    chk_clk_high_width: assert property ($fell(shiftClk) |-> hiCnt_q >= 8'd15)
        else $error("shift clock high time too short");
    chk_clk_low_width: assert property ($rose(shiftClk) |-> loCnt_q >= 8'd15)
        else $error("shift clock low time too short");
    chk_strobe_width: assert property ($fell(strobe) |-> stbCnt_q >= 8'd10)
        else $error("strobe pulse too short");
    chk_strobe_gap: assert property ($rose(strobe) |-> !shiftClk && loCnt_q >= 8'd30)
        else $error("strobe too soon after shift clock");
    chk_data_setup: assert property ($rose(shiftClk) |-> $stable(serData))
        else $error("serial data moved at clock rise");
    chk_cascade_follows: assert property ($rose(shiftClk) |-> ##5 cascadeOut == shadow_q[7])
        else $error("cascade output differs from reference chain");
    chk_cascade_static: assert property ($changed(cascadeOut) |-> riseCnt_q <= 8'd5)
        else $error("cascade output moved without a clock rise");
    chk_enable_pulse: assert property ($rose(outEnN) |=> outEnN [*8])
        else $error("enable reset pulse too short");
endmodule

// ### sld_oc_filter.sv
// per-channel over-current glitch filter and fault latch
// assumes overCur is already synchronised to clk
module sld_oc_filter #(
    parameter int GLITCH_CYC = sld_pkg::SLD_GLITCH_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // detector and clear
    input wire logic overCur,
    input wire logic faultClr,
    // latched fault
    output logic fault
);
    import sld_pkg::*;
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [SLD_CNT_W-1:0] cnt;   // cycles of continuous over-current
        logic fault;                 // latched trip
    } sld_oc_t;
    sld_oc_t st_q, st_d;

    // count a run; trip only past the reject time
    always_comb begin
        st_d = st_q;
        if (!overCur) begin
            st_d.cnt = '0;
        end else if (st_q.cnt < SLD_CNT_W'(GLITCH_CYC)) begin
            st_d.cnt = st_q.cnt + SLD_CNT_W'(1);
        end
        // trip beats clear so a long event is never lost
        if (faultClr) begin
            st_d.fault = 1'b0;
        end
        if (overCur && st_q.cnt >= SLD_CNT_W'(GLITCH_CYC)) begin
            st_d.fault = 1'b1;
        end
    end

    // register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign fault = st_q.fault;
endmodule

// ### sld_pkg.sv
// package of constants and types for the serial latched driver pair
// assumes a single 100 MHz system clock in every file that imports it
package sld_pkg;
    // ****************************************************************
    // widths and timing
    // ****************************************************************
    localparam int SLD_CHANNELS = 8;                      // driver channels
    localparam int SLD_CLK_MHZ = 100;                     // system clock rate
    localparam int SLD_SCLK_PULSE_NS = 150;               // least shift-clock high/low time
    localparam int SLD_STROBE_PULSE_NS = 100;             // least strobe high time
    localparam int SLD_CLK_TO_STROBE_NS = 300;            // least shift edge to strobe gap
    localparam int SLD_GLITCH_NS = 2000;                  // over-current glitch reject time
    localparam int SLD_SCLK_PULSE_CYC = (SLD_SCLK_PULSE_NS * SLD_CLK_MHZ + 999) / 1000;
    localparam int SLD_STROBE_PULSE_CYC = (SLD_STROBE_PULSE_NS * SLD_CLK_MHZ + 999) / 1000;
    localparam int SLD_CLK_TO_STROBE_CYC = (SLD_CLK_TO_STROBE_NS * SLD_CLK_MHZ + 999) / 1000;
    localparam int SLD_GLITCH_CYC = (SLD_GLITCH_NS * SLD_CLK_MHZ + 999) / 1000;
    localparam int SLD_CNT_W = 12;                        // width of timing counters

    // ****************************************************************
    // controller register map (APB, byte addresses)
    // ****************************************************************
    localparam logic [7:0] SLD_REG_CTRL = 8'h00;          // bit0 go, bit1 enable-off, bit2 reset pulse
    localparam logic [7:0] SLD_REG_DATA = 8'h04;          // pattern to send
    localparam logic [7:0] SLD_REG_STAT = 8'h08;          // bit0 busy
    localparam logic [7:0] SLD_REG_IRQ_STAT = 8'h0C;      // bit0 done, read only
    localparam logic [7:0] SLD_REG_IRQ_CLR = 8'h10;       // write one to clear
    localparam logic [7:0] SLD_REG_IRQ_EN = 8'h14;        // enable mask
    localparam int SLD_CTRL_GO = 0;
    localparam int SLD_CTRL_OEOFF = 1;
    localparam int SLD_CTRL_RST = 2;
    localparam logic [31:0] SLD_RST_VAL = 32'h0000_0000;  // reset value of every register

    // controller sequencer states
    typedef enum logic [2:0] {SLD_IDLE, SLD_SETUP, SLD_HIGH, SLD_GAP, SLD_STROBE,
        SLD_RSTP} sld_state_t;
endpackage

// ### tb.sv
// self-checking bench: controller end joined to device end over the link
// assumes the package, interface and both design ends are compiled first
module tb;
    import sld_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, overCur, sinkOn, faultFlag, lastPat;
    logic [31:0] pwdata, prdata;
    logic overTemp, lowSupplyLockout;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    sld_link_if link_if ();
    sld_ctrl u_sld_ctrl (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link_if));
    sld_device u_sld_device (.clk(clk), .sys_rst(sys_rst), .link(link_if), .overCur(overCur),
        .overTemp(overTemp), .lowSupplyLockout(lowSupplyLockout), .sinkOn(sinkOn),
        .faultFlag(faultFlag));
    sld_link_sva u_sld_link_sva (.clk(clk), .sys_rst(sys_rst), .serData(link_if.serData),
        .shiftClk(link_if.shiftClk), .strobe(link_if.strobe), .outEnN(link_if.outEnN),
        .cascadeOut(link_if.cascadeOut));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask

    // one apb transfer; waits on pready, the bench watchdog catches a dead slave
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // request stands until the edge at which pready is sampled high
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic expErr);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
        chk(32'(er), 32'(expErr));
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0000_0000, rd, er);
        chk(32'(er), 32'(expErr));
        if (!expErr) chk(rd, exp);
    endtask

    // waits for the done interrupt, then clears it
    task automatic wait_done();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk(32'(irq), 32'h0000_0001);
        repeat (12) @(posedge clk);
        wr(SLD_REG_IRQ_CLR, 32'h0000_0001, 1'b0);
        rdchk(SLD_REG_IRQ_STAT, 32'h0000_0000, 1'b0);
        chk(32'(irq), 32'h0000_0000);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs();
        rdchk(SLD_REG_CTRL, SLD_RST_VAL, 1'b0);
        rdchk(SLD_REG_IRQ_EN, SLD_RST_VAL, 1'b0);
        rdchk(8'h20, 32'h0000_0000, 1'b1);
        wr(SLD_REG_STAT, 32'h0000_0001, 1'b1);
    endtask

    // old outputs must hold while shifting, new ones land after strobe
    task automatic t_send(input logic [7:0] pat);
        wr(SLD_REG_DATA, 32'(pat), 1'b0);
        wr(SLD_REG_CTRL, 32'h0000_0001, 1'b0);
        rdchk(SLD_REG_STAT, 32'h0000_0001, 1'b0);
        repeat (100) @(posedge clk);
        chk(32'(sinkOn), 32'(lastPat));
        wait_done();
        chk(32'(sinkOn), 32'(pat));
        chk(32'(link_if.cascadeOut), 32'(pat[7]));
        lastPat = pat;
    endtask

    task automatic t_enable();
        wr(SLD_REG_CTRL, 32'h0000_0002, 1'b0);
        repeat (8) @(posedge clk);
        chk(32'(sinkOn), 32'h0000_0000);
        wr(SLD_REG_CTRL, 32'h0000_0000, 1'b0);
        repeat (8) @(posedge clk);
        chk(32'(sinkOn), 32'(lastPat));
    endtask

    // shutdown sensors are not latched: outputs return by themselves
    task automatic t_shutdown(input logic lockSel);
        if (lockSel) lowSupplyLockout <= 1'b1;
        else overTemp <= 1'b1;
        repeat (8) @(posedge clk);
        chk(32'(sinkOn), 32'h0000_0000);
        lowSupplyLockout <= 1'b0;
        overTemp <= 1'b0;
        repeat (8) @(posedge clk);
        chk(32'(sinkOn), 32'(lastPat));
    endtask

    task automatic t_overcur();
        overCur <= 8'h04;
        repeat (100) @(posedge clk);
        overCur <= 8'h00;
        repeat (10) @(posedge clk);
        chk(32'(faultFlag), 32'h0000_0000);
        overCur <= 8'h04;
        repeat (300) @(posedge clk);
        overCur <= 8'h00;
        repeat (10) @(posedge clk);
        chk(32'(faultFlag), 32'h0000_0004);
        chk(32'(sinkOn), 32'h0000_00FB);
        wr(SLD_REG_CTRL, 32'h0000_0004, 1'b0);
        wait_done();
        chk(32'(faultFlag), 32'h0000_0000);
        chk(32'(sinkOn), 32'h0000_00FF);
    endtask

    // masked done sets status but keeps the line low
    task automatic t_mask();
        wr(SLD_REG_IRQ_EN, 32'h0000_0000, 1'b0);
        wr(SLD_REG_CTRL, 32'h0000_0004, 1'b0);
        repeat (40) @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        rdchk(SLD_REG_IRQ_STAT, 32'h0000_0001, 1'b0);
        wr(SLD_REG_IRQ_EN, 32'h0000_0001, 1'b0);
        wait_done();
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial begin
        logic [7:0] pats [6];
        pats = '{8'hA5, 8'h5A, 8'h01, 8'h80, 8'hFF, 8'h00};
        sys_rst = 1'b1;
        {psel, penable, pwrite, overTemp, lowSupplyLockout} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        overCur = 8'h00;
        lastPat = 8'h00;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        wr(SLD_REG_IRQ_EN, 32'h0000_0001, 1'b0);
        foreach (pats[i]) t_send(pats[i]);
        t_send(8'hFF);
        t_enable();
        t_shutdown(1'b0);
        t_shutdown(1'b1);
        t_overcur();
        t_mask();
        tally_and_finish();
    end
endmodule
